// File: ssfb_pkg.sv
// Constants, register map and carrier types of the soft start flag blanking
// block. Assumes one 100 MHz core clock shared with detectors and PWM engine.
package ssfb_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned NFLAG  = 15;
  localparam int unsigned NSR    = 4;

  // --------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------
  localparam logic [15:0] REEN_DELAY_OFS   = 16'hFE06;
  localparam logic [15:0] SOFT_BLANK_OFS   = 16'hFE07;
  localparam logic [15:0] BAL_SR_OFS       = 16'hFE08;
  localparam logic [15:0] FLAG_LO_OFS      = 16'hFE10;
  localparam logic [15:0] FLAG_HI_OFS      = 16'hFE11;
  localparam logic [15:0] STATUS_OFS       = 16'hFE12;
  localparam logic [15:0] PWM_DIS_OFS      = 16'hFE60;
  localparam logic [15:0] BAL_SEL_OFS      = 16'hFE72;
  localparam logic [15:0] SR_ASSIGN_OFS    = 16'hFE81;

  localparam logic [7:0] REG_RESET = 8'h00;

  // --------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------
  localparam int unsigned DELAY_SEL_LSB   = 6;
  localparam int unsigned BAL_SEL_BIT     = 7;
  localparam int unsigned LINE_REEN_BIT   = 6;
  localparam int unsigned FIRST_SAVE_BIT  = 5;
  localparam int unsigned SHUT_NOW_BIT    = 4;
  localparam int unsigned BAL_BLANK_BIT   = 3;
  localparam int unsigned KEEP_OC_C_BIT   = 6;
  localparam int unsigned KEEP_OV_B_BIT   = 5;
  localparam int unsigned KEEP_OV_A_BIT   = 4;
  localparam int unsigned KEEP_CS2_B_BIT  = 3;
  localparam int unsigned KEEP_CS2_A_BIT  = 2;
  localparam int unsigned KEEP_CS1_B_BIT  = 1;
  localparam int unsigned KEEP_CS1_A_BIT  = 0;

  // Flag vector positions
  localparam int unsigned F_EXT   = 0;
  localparam int unsigned F_OT1   = 1;
  localparam int unsigned F_OT2   = 2;
  localparam int unsigned F_LINE  = 3;
  localparam int unsigned F_REV_A = 4;
  localparam int unsigned F_REV_B = 5;
  localparam int unsigned F_UV_A  = 6;
  localparam int unsigned F_UV_B  = 7;
  localparam int unsigned F_OC_C  = 8;
  localparam int unsigned F_OV_A  = 9;
  localparam int unsigned F_OV_B  = 10;
  localparam int unsigned F_CS1_A = 11;
  localparam int unsigned F_CS1_B = 12;
  localparam int unsigned F_CS2_A = 13;
  localparam int unsigned F_CS2_B = 14;

  // Channel codes, also the rectifier assignment encoding
  localparam logic [1:0] CH_A = 2'h0;
  localparam logic [1:0] CH_B = 2'h1;
  localparam logic [1:0] CH_C = 2'h2;

  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned REEN_BASE_MS  = 250;
  localparam int unsigned REEN_BASE_CYC = REEN_BASE_MS * (CLK_HZ / 1000);

  typedef struct packed {
    logic [7:0] reen_delay;
    logic [7:0] soft_blank;
    logic [7:0] bal_sr;
    logic [7:0] pwm_dis;
    logic [7:0] bal_sel;
    logic [7:0] sr_assign;
  } ssfb_cfg_t;

endpackage

// File: ssfb_top.sv
// Soft start flag blanking, shutdown sequencing and rectifier gating.
// Assumes flag events, soft start levels and the cycle end strobe come from
// logic on I_REF_CLK; the register port is a plain same-clock strobe bus.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module ssfb_top #(
  parameter int unsigned REEN_BASE_CYC = ssfb_pkg::REEN_BASE_CYC
) (
  input  wire logic                        I_REF_CLK,
  input  wire logic                        I_RST_B,
  input  wire logic [ssfb_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [7:0]                  i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  input  wire logic [ssfb_pkg::NFLAG-1:0]  i_flag_evt,
  input  wire logic [2:0]                  i_soft_start,
  input  wire logic                        i_pwm_cycle_end,
  output logic [7:0]                       o_rdata,
  output logic [ssfb_pkg::NFLAG-1:0]       o_flag,
  output logic [ssfb_pkg::NFLAG-1:0]       o_flag_act,
  output logic                             o_pwm_stop,
  output logic                             o_soft_start_req,
  output logic [ssfb_pkg::NSR-1:0]         o_sr_disable,
  output logic                             o_bal_blank,
  output logic [3:0]                       o_first_id,
  output logic                             o_first_id_save
);

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  ssfb_pkg::ssfb_cfg_t cfg;
  logic [ssfb_pkg::NFLAG-1:0] flag_q;
  logic [31:0]                reen_cnt;
  logic [3:0]                 first_id;
  logic                       first_seen;

  typedef enum logic [1:0] {ST_RUN, ST_WAIT_END, ST_STOPPED, ST_REEN}
    ssfb_state_t;
  ssfb_state_t state;
  ssfb_state_t next_state;

  wire hit_delay  = i_addr == ssfb_pkg::REEN_DELAY_OFS;
  wire hit_blank  = i_addr == ssfb_pkg::SOFT_BLANK_OFS;
  wire hit_bal_sr = i_addr == ssfb_pkg::BAL_SR_OFS;
  wire hit_flg_lo = i_addr == ssfb_pkg::FLAG_LO_OFS;
  wire hit_flg_hi = i_addr == ssfb_pkg::FLAG_HI_OFS;
  wire hit_status = i_addr == ssfb_pkg::STATUS_OFS;
  wire hit_pwmdis = i_addr == ssfb_pkg::PWM_DIS_OFS;
  wire hit_balsel = i_addr == ssfb_pkg::BAL_SEL_OFS;
  wire hit_assign = i_addr == ssfb_pkg::SR_ASSIGN_OFS;

  // Software clear of latched flags, write one to clear
  wire [15:0] clr_wide = {(i_wr && hit_flg_hi) ? i_wdata : 8'h00,
                          (i_wr && hit_flg_lo) ? i_wdata : 8'h00};
  wire [ssfb_pkg::NFLAG-1:0] flag_clr = clr_wide[ssfb_pkg::NFLAG-1:0];

  wire [15:0] flag_wide = {1'b0, flag_q};
  wire [7:0] status_rd = {2'h0, state, first_seen ? first_id : 4'h0};

  wire [7:0] next_rdata =
      hit_delay  ? cfg.reen_delay :
      hit_blank  ? cfg.soft_blank :
      hit_bal_sr ? cfg.bal_sr     :
      hit_flg_lo ? flag_wide[7:0] :
      hit_flg_hi ? flag_wide[15:8] :
      hit_status ? status_rd      :
      hit_pwmdis ? cfg.pwm_dis    :
      hit_balsel ? cfg.bal_sel    :
      hit_assign ? cfg.sr_assign  : 8'h00;

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cfg <= {6{ssfb_pkg::REG_RESET}};
    end else if (i_wr) begin
      if (hit_delay)  cfg.reen_delay <= i_wdata;
      if (hit_blank)  cfg.soft_blank <= i_wdata;
      if (hit_bal_sr) cfg.bal_sr     <= i_wdata;
      if (hit_pwmdis) cfg.pwm_dis    <= i_wdata;
      if (hit_balsel) cfg.bal_sel    <= i_wdata;
      if (hit_assign) cfg.sr_assign  <= i_wdata;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? next_rdata : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Flag latching and blanking
  // ----------------------------------------------------------------------
  wire ss_a   = i_soft_start[0];
  wire ss_b   = i_soft_start[1];
  wire ss_c   = i_soft_start[2];
  wire any_ss = |i_soft_start;
  wire in_reen = state == ST_REEN;
  wire [7:0] keep = cfg.soft_blank;

  logic [ssfb_pkg::NFLAG-1:0] blank;
  always_comb begin
    blank = '0;
    // Blank terms follow the live soft start levels, so they drop the
    // moment a channel's soft start ends; the line term also holds during re-enable
    blank[ssfb_pkg::F_EXT]   = any_ss;
    blank[ssfb_pkg::F_OT1]   = any_ss;
    blank[ssfb_pkg::F_OT2]   = any_ss;
    blank[ssfb_pkg::F_LINE]  = any_ss ||
        (in_reen && cfg.bal_sr[ssfb_pkg::LINE_REEN_BIT]);
    blank[ssfb_pkg::F_REV_A] = ss_a;
    blank[ssfb_pkg::F_UV_A]  = ss_a;
    blank[ssfb_pkg::F_REV_B] = ss_b;
    blank[ssfb_pkg::F_UV_B]  = ss_b;
    blank[ssfb_pkg::F_OC_C]  = ss_c && !keep[ssfb_pkg::KEEP_OC_C_BIT];
    blank[ssfb_pkg::F_OV_B]  = ss_b && !keep[ssfb_pkg::KEEP_OV_B_BIT];
    blank[ssfb_pkg::F_OV_A]  = ss_a && !keep[ssfb_pkg::KEEP_OV_A_BIT];
    blank[ssfb_pkg::F_CS2_A] = ss_a && !keep[ssfb_pkg::KEEP_CS2_A_BIT];
    blank[ssfb_pkg::F_CS1_A] = ss_a && !keep[ssfb_pkg::KEEP_CS1_A_BIT];
    blank[ssfb_pkg::F_CS2_B] = ss_b && !keep[ssfb_pkg::KEEP_CS2_B_BIT];
    blank[ssfb_pkg::F_CS1_B] = ss_b && !keep[ssfb_pkg::KEEP_CS1_B_BIT];
  end

  // A blanked flag still latches; only its action is masked
  wire [ssfb_pkg::NFLAG-1:0] next_flag = i_flag_evt | (flag_q & ~flag_clr);
  wire [ssfb_pkg::NFLAG-1:0] act = flag_q & ~blank;
  wire trip = |act;

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      flag_q     <= '0;
      o_flag     <= '0;
      o_flag_act <= '0;
    end else begin
      flag_q     <= next_flag;
      o_flag     <= next_flag;
      o_flag_act <= act;
    end
  end

  // ----------------------------------------------------------------------
  // Shutdown and re-enable sequencing
  // ----------------------------------------------------------------------
  function automatic logic [3:0] first_set(
    input logic [ssfb_pkg::NFLAG-1:0] v
  );
    logic [3:0] id;
    id = 4'hF;
    for (int i = ssfb_pkg::NFLAG - 1; i >= 0; i--) begin
      if (v[i]) begin
        id = 4'(i);
      end
    end
    return id;
  endfunction

  wire shut_now = cfg.bal_sr[ssfb_pkg::SHUT_NOW_BIT];
  wire [1:0] delay_sel =
    cfg.reen_delay[ssfb_pkg::DELAY_SEL_LSB +: 2];
  // Delay doubles per select step: 250 ms, 500 ms, 1 s, 2 s
  wire [31:0] reen_load = 32'(REEN_BASE_CYC) << delay_sel;
  wire reen_done = in_reen && (reen_cnt <= 32'h0000_0001);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (trip) begin
          next_state = shut_now ? ST_STOPPED : ST_WAIT_END;
        end
      end
      ST_WAIT_END: begin
        if (i_pwm_cycle_end) begin
          next_state = ST_STOPPED;
        end
      end
      ST_STOPPED: begin
        if (flag_q == '0) begin
          next_state = ST_REEN;
        end
      end
      ST_REEN: begin
        if (trip) begin
          next_state = ST_STOPPED;
        end else if (reen_done) begin
          next_state = ST_RUN;
        end
      end
    endcase
  end

  wire enter_reen = state == ST_STOPPED && next_state == ST_REEN;
  wire first_trip = state == ST_RUN && trip && !first_seen;
  wire stop_next  = next_state == ST_STOPPED || next_state == ST_REEN;

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state            <= ST_RUN;
      reen_cnt         <= 32'h0000_0000;
      o_pwm_stop       <= 1'b0;
      o_soft_start_req <= 1'b0;
    end else begin
      state            <= next_state;
      reen_cnt         <= enter_reen ? reen_load :
                          in_reen ? reen_cnt - 32'h0000_0001 : reen_cnt;
      o_pwm_stop       <= stop_next;
      o_soft_start_req <= reen_done && !trip;
    end
  end

  // First flag identity is kept until a full re-enable completes
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      first_id        <= 4'h0;
      first_seen      <= 1'b0;
      o_first_id      <= 4'h0;
      o_first_id_save <= 1'b0;
    end else begin
      if (first_trip) begin
        first_id   <= first_set(act);
        o_first_id <= first_set(act);
        first_seen <= 1'b1;
      end else if (reen_done && !trip) begin
        first_seen <= 1'b0;
      end
      o_first_id_save <= first_trip &&
                         cfg.bal_sr[ssfb_pkg::FIRST_SAVE_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Volt-second balance blanking and rectifier gating
  // ----------------------------------------------------------------------
  wire bal_on_c  = cfg.bal_sel[ssfb_pkg::BAL_SEL_BIT];
  wire bal_ss    = bal_on_c ? ss_c : ss_a;
  wire next_bal_blank =
    cfg.bal_sr[ssfb_pkg::BAL_BLANK_BIT] && bal_ss;

  logic [ssfb_pkg::NSR-1:0] next_sr_dis;
  genvar g;
  generate
    for (g = 0; g < ssfb_pkg::NSR; g++) begin : g_sr
      wire [1:0] ch = cfg.sr_assign[2*g +: 2];
      wire ch_ss = (ch == ssfb_pkg::CH_A) ? ss_a :
                   (ch == ssfb_pkg::CH_B) ? ss_b :
                   (ch == ssfb_pkg::CH_C) ? ss_c : 1'b0;
      // Channel bit 0/1/2 of the control register matches channel code
      wire ch_force = (ch == ssfb_pkg::CH_C) ? cfg.bal_sr[2] :
                      (ch == ssfb_pkg::CH_B) ? cfg.bal_sr[1] :
                      (ch == ssfb_pkg::CH_A) ? cfg.bal_sr[0] :
                      1'b0;
      assign next_sr_dis[g] = ch_ss &&
                              (ch_force || cfg.pwm_dis[g]);
    end
  endgenerate

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      o_bal_blank  <= 1'b0;
      o_sr_disable <= '0;
    end else begin
      o_bal_blank  <= next_bal_blank;
      o_sr_disable <= next_sr_dis;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);

  flag_latch_a: assert property (
    (i_flag_evt != '0) |=> ((o_flag & $past(i_flag_evt)) == $past(i_flag_evt))
  ) else $error("flag event not latched");

  common_blank_a: assert property (
    any_ss |=> (o_flag_act[3:0] == 4'h0)
  ) else $error("common flag acted during soft start");

  chan_a_blank_a: assert property (
    ss_a |=> (!o_flag_act[ssfb_pkg::F_REV_A] && !o_flag_act[ssfb_pkg::F_UV_A])
  ) else $error("channel A flag acted during A soft start");

  oc_c_keep_a: assert property (
    (ss_c && flag_q[ssfb_pkg::F_OC_C] && keep[ssfb_pkg::KEEP_OC_C_BIT])
      |=> o_flag_act[ssfb_pkg::F_OC_C]
  ) else $error("channel C overcurrent wrongly blanked");

  ov_b_blank_a: assert property (
    (ss_b && !keep[ssfb_pkg::KEEP_OV_B_BIT]) |=> !o_flag_act[ssfb_pkg::F_OV_B]
  ) else $error("channel B overvoltage not blanked");

  stop_now_a: assert property (
    (state == ST_RUN && trip && shut_now) |=> o_pwm_stop
  ) else $error("immediate shutdown missed");

  stop_wait_a: assert property (
    (state == ST_RUN && trip && !shut_now) |=> !o_pwm_stop ##0
      (state == ST_WAIT_END)
  ) else $error("deferred shutdown stopped early");

  reen_load_a: assert property (
    enter_reen |=> (reen_cnt == $past(reen_load))
  ) else $error("re-enable delay not loaded");

  bal_blank_a: assert property (
    (cfg.bal_sr[ssfb_pkg::BAL_BLANK_BIT] && ss_a && !bal_on_c) |=> o_bal_blank
  ) else $error("balance not blanked in channel A start");

  sr_release_a: assert property (
    (i_soft_start == 3'h0) |=> (o_sr_disable == '0 && !o_bal_blank)
  ) else $error("rectifier gating held after soft start");

  id_save_a: assert property (
    o_first_id_save |-> $past(cfg.bal_sr[ssfb_pkg::FIRST_SAVE_BIT])
  ) else $error("first flag saved while saving is off");

  chan_b_blank_a: assert property (
    ss_b |=> (!o_flag_act[ssfb_pkg::F_REV_B] && !o_flag_act[ssfb_pkg::F_UV_B])
  ) else $error("channel B flag acted during B soft start");

  ov_a_blank_a: assert property (
    (ss_a && !keep[ssfb_pkg::KEEP_OV_A_BIT]) |=> !o_flag_act[ssfb_pkg::F_OV_A]
  ) else $error("channel A overvoltage not blanked");

  cs_a_blank_a: assert property (
    (ss_a && !keep[ssfb_pkg::KEEP_CS1_A_BIT] &&
     !keep[ssfb_pkg::KEEP_CS2_A_BIT])
      |=> (!o_flag_act[ssfb_pkg::F_CS1_A] && !o_flag_act[ssfb_pkg::F_CS2_A])
  ) else $error("channel A sense overcurrent not blanked");

  cs_b_blank_a: assert property (
    (ss_b && !keep[ssfb_pkg::KEEP_CS1_B_BIT] &&
     !keep[ssfb_pkg::KEEP_CS2_B_BIT])
      |=> (!o_flag_act[ssfb_pkg::F_CS1_B] && !o_flag_act[ssfb_pkg::F_CS2_B])
  ) else $error("channel B sense overcurrent not blanked");

  line_reen_a: assert property (
    (in_reen && cfg.bal_sr[ssfb_pkg::LINE_REEN_BIT])
      |=> !o_flag_act[ssfb_pkg::F_LINE]
  ) else $error("line sense acted during re-enable");

  stop_cycle_end_a: assert property (
    (state == ST_WAIT_END && i_pwm_cycle_end) |=> o_pwm_stop
  ) else $error("deferred shutdown missed cycle end");

  bal_c_blank_a: assert property (
    (cfg.bal_sr[ssfb_pkg::BAL_BLANK_BIT] && ss_c && bal_on_c) |=> o_bal_blank
  ) else $error("balance not blanked in channel C start");

  sr_c_force_a: assert property (
    (ss_c && cfg.bal_sr[2] && cfg.sr_assign[5:4] == ssfb_pkg::CH_C)
      |=> o_sr_disable[2]
  ) else $error("channel C rectifier not forced off");

  sr_b_force_a: assert property (
    (ss_b && cfg.bal_sr[1] && cfg.sr_assign[3:2] == ssfb_pkg::CH_B)
      |=> o_sr_disable[1]
  ) else $error("channel B rectifier not forced off");

  sr_a_force_a: assert property (
    (ss_a && cfg.bal_sr[0] && cfg.sr_assign[1:0] == ssfb_pkg::CH_A)
      |=> o_sr_disable[0]
  ) else $error("channel A rectifier not forced off");

  req_release_a: assert property (
    o_soft_start_req |-> (!o_pwm_stop && state == ST_RUN)
  ) else $error("soft start requested while stopped");

endmodule

// File: ssfb_stage_model.sv
// Behavioural power stage and fault sensing around the blanking block.
// Assumes the bench commands fault events and soft start levels.
`timescale 1ns/1ps
module ssfb_stage_model #(
  parameter int unsigned PERIOD = 8
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_run,
  input  wire logic [14:0] i_evt,
  input  wire logic [2:0]  i_ss,
  output logic [14:0]      o_flag_evt,
  output logic [2:0]       o_soft_start,
  output logic             o_cycle_end
);
  logic [7:0] cnt;

  assign o_flag_evt   = i_evt;
  assign o_soft_start = i_ss;

  // Cycle end strobe stays silent while held, to expose early shutdown
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt         <= 8'h00;
      o_cycle_end <= 1'b0;
    end else begin
      cnt         <= (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
      o_cycle_end <= i_run && (cnt == 8'(PERIOD - 1));
    end
  end
endmodule

// File: ssfb_tb_top.sv
// Self-checking bench for the soft start flag blanking block.
// Assumes a shortened re-enable base count of four cycles.
`timescale 1ns/1ps
module ssfb_tb_top;
  localparam int unsigned BASE = 4;
  logic        I_REF_CLK = 1'b0;
  logic        I_RST_B   = 1'b0;
  logic [15:0] addr      = 16'h0000;
  logic [7:0]  wdata     = 8'h00;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic [14:0] evt       = 15'h0000;
  logic [2:0]  ss        = 3'h0;
  logic        run       = 1'b0;
  logic [14:0] flag_evt, flag, flag_act;
  logic [2:0]  soft_start;
  logic        cyc_end, pwm_stop, ss_req, bal_blank, save;
  logic [7:0]  rdata;
  logic [3:0]  sr_dis, first_id;
  int          miscompares = 0;
  int          n_tests     = 0;
  int          cycles      = 0;
  logic        saw_save    = 1'b0;

  always #5 I_REF_CLK = ~I_REF_CLK;

  ssfb_stage_model stage (.i_clk(I_REF_CLK), .i_rst_b(I_RST_B),
    .i_run(run), .i_evt(evt), .i_ss(ss), .o_flag_evt(flag_evt),
    .o_soft_start(soft_start), .o_cycle_end(cyc_end));

  ssfb_top #(.REEN_BASE_CYC(BASE)) uut (.I_REF_CLK(I_REF_CLK),
    .I_RST_B(I_RST_B), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .i_flag_evt(flag_evt), .i_soft_start(soft_start),
    .i_pwm_cycle_end(cyc_end), .o_rdata(rdata), .o_flag(flag),
    .o_flag_act(flag_act), .o_pwm_stop(pwm_stop),
    .o_soft_start_req(ss_req), .o_sr_disable(sr_dis),
    .o_bal_blank(bal_blank), .o_first_id(first_id),
    .o_first_id_save(save));

  // Ceiling well above the few thousand cycles the tests need
  always @(posedge I_REF_CLK) begin
    cycles <= cycles + 1;
    if (save === 1'b1)
      saw_save <= 1'b1;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic check(string what, logic [15:0] got, logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(logic [15:0] a, logic [7:0] d);
    @(posedge I_REF_CLK);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge I_REF_CLK);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(logic [15:0] a, output logic [7:0] d);
    @(posedge I_REF_CLK);
    addr <= a;
    rd   <= 1'b1;
    @(posedge I_REF_CLK);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge I_REF_CLK);
    #1;
  endtask

  task automatic pulse(int f);
    @(posedge I_REF_CLK);
    evt[f] <= 1'b1;
    @(posedge I_REF_CLK);
    evt    <= 15'h0000;
  endtask

  task automatic clear_flags();
    wr_reg(16'hFE10, 8'hFF);
    wr_reg(16'hFE11, 8'h7F);
  endtask

  function automatic logic exp_blank(int f, logic [2:0] s, logic [7:0] b);
    case (f)
      0, 1, 2, 3: return |s;
      4, 6:       return s[0];
      5, 7:       return s[1];
      8:          return s[2] & ~b[6];
      9:          return s[0] & ~b[4];
      10:         return s[1] & ~b[5];
      11:         return s[0] & ~b[0];
      12:         return s[1] & ~b[1];
      13:         return s[0] & ~b[2];
      default:    return s[1] & ~b[3];
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] d;
    rd_reg(ssfb_pkg::SOFT_BLANK_OFS, d);
    check("blank reset", 16'(d), 16'h0000);
    rd_reg(ssfb_pkg::BAL_SR_OFS, d);
    check("control reset", 16'(d), 16'h0000);
    wr_reg(ssfb_pkg::SOFT_BLANK_OFS, 8'hA5);
    wr_reg(ssfb_pkg::BAL_SR_OFS, 8'h5A);
    wr_reg(16'hFE00, 8'hFF);
    rd_reg(ssfb_pkg::SOFT_BLANK_OFS, d);
    check("blank rw", 16'(d), 16'h00A5);
    rd_reg(ssfb_pkg::BAL_SR_OFS, d);
    check("control rw", 16'(d), 16'h005A);
    rd_reg(16'hFE00, d);
    check("unmapped", 16'(d), 16'h0000);
    wr_reg(ssfb_pkg::BAL_SR_OFS, 8'h00);
  endtask

  task automatic t_blank();
    logic [2:0] sl [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
    logic [7:0] b;
    for (int i = 0; i < 5; i++) begin
      for (int k = 0; k < 2; k++) begin
        b = k ? 8'h7F : 8'h00;
        wr_reg(ssfb_pkg::SOFT_BLANK_OFS, b);
        for (int f = 0; f < 15; f++) begin
          clear_flags();
          ss <= sl[i];
          pulse(f);
          tick(2);
          check("flag set", 16'(flag[f]), 16'h0001);
          check("flag act", 16'(flag_act[f]),
                16'(!exp_blank(f, sl[i], b)));
        end
      end
    end
    ss <= 3'h0;
  endtask

  task automatic t_gate();
    logic [7:0] c, p;
    logic [3:0] e;
    wr_reg(ssfb_pkg::SR_ASSIGN_OFS, 8'hE4);
    for (int m = 0; m < 4; m++) begin
      c = m[0] ? 8'h0F : 8'h00;
      p = m[1] ? 8'h0F : 8'h00;
      wr_reg(ssfb_pkg::BAL_SR_OFS, c);
      wr_reg(ssfb_pkg::PWM_DIS_OFS, p);
      wr_reg(ssfb_pkg::BAL_SEL_OFS, m[1] ? 8'h80 : 8'h00);
      for (int s = 0; s < 8; s++) begin
        @(posedge I_REF_CLK);
        ss <= s[2:0];
        tick(2);
        // Output g sits on channel g; the fourth is unassigned
        for (int g = 0; g < 3; g++)
          e[g] = s[g] & (c[g] | p[g]);
        e[3] = 1'b0;
        check("sr disable", 16'(sr_dis), 16'(e));
        check("bal blank", 16'(bal_blank),
              16'(c[3] & (m[1] ? s[2] : s[0])));
      end
    end
    @(posedge I_REF_CLK);
    ss <= 3'h0;
  endtask

  task automatic t_line();
    wr_reg(ssfb_pkg::REEN_DELAY_OFS, 8'hC0);
    wr_reg(ssfb_pkg::BAL_SR_OFS, 8'h50);
    clear_flags();
    tick(80);
    pulse(0);
    tick(3);
    clear_flags();
    tick(4);
    pulse(3);
    tick(3);
    check("line flag", 16'(flag[3]), 16'h0001);
    check("line act", 16'(flag_act[3]), 16'h0000);
    wr_reg(ssfb_pkg::BAL_SR_OFS, 8'h10);
    tick(2);
    check("line act open", 16'(flag_act[3]), 16'h0001);
  endtask

  task automatic t_shut(logic now, logic sv, logic [1:0] sel, int f);
    int n;
    logic [7:0] d;
    wr_reg(ssfb_pkg::REEN_DELAY_OFS, {sel, 6'h00});
    wr_reg(ssfb_pkg::BAL_SR_OFS, {2'b00, sv, now, 4'h0});
    clear_flags();
    tick(80);
    run      <= 1'b0;
    saw_save <= 1'b0;
    pulse(f);
    tick(3);
    check("stop", 16'(pwm_stop), 16'(now));
    if (!now) begin
      run <= 1'b1;
      tick(12);
      check("stop at cycle end", 16'(pwm_stop), 16'h0001);
    end
    check("first id", 16'(first_id), 16'(f));
    check("id save", 16'(saw_save), 16'(sv));
    rd_reg(ssfb_pkg::STATUS_OFS, d);
    check("status", 16'(d), {8'h00, 4'h2, 4'(f)});
    rd_reg(f < 8 ? ssfb_pkg::FLAG_LO_OFS : ssfb_pkg::FLAG_HI_OFS, d);
    check("flag reg", 16'(d), 16'(1 << (f % 8)));
    // Clear only the byte holding f, so the delay counts from that edge
    wr_reg(f < 8 ? ssfb_pkg::FLAG_LO_OFS : ssfb_pkg::FLAG_HI_OFS, 8'hFF);
    n = 0;
    while (ss_req !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    check("reenable delay", 16'(n >= (BASE << sel) &&
          n <= (BASE << sel) + 4), 16'h0001);
    check("stop released", 16'(pwm_stop), 16'h0000);
    run <= 1'b1;
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge I_REF_CLK);
    I_RST_B <= 1'b1;
    run     <= 1'b1;
    t_regs();
    t_blank();
    t_gate();
    t_line();
    t_shut(1'b1, 1'b1, 2'h0, 9);
    t_shut(1'b0, 1'b0, 2'h3, 14);
    t_shut(1'b1, 1'b0, 2'h1, 0);
    t_shut(1'b0, 1'b1, 2'h2, 5);
    wrap_up();
  end
endmodule
